// ### crr_pkg.sv
// Constants, carrier structs and state types of the result register block.
// Assumes one 125 MHz clock, an APB master and a same-clock store strobe.
package crr_pkg;

  // Clock rate
  localparam int unsigned CRR_CLK_MHZ      = 125;

  // Sizes
  localparam int unsigned CRR_NUM_SLOTS    = 4;
  localparam int unsigned CRR_RESULT_W     = 12;
  localparam int unsigned CRR_ADDR_W       = 8;
  localparam int unsigned CRR_DATA_W       = 32;
  localparam int unsigned CRR_EVT_W        = 8;

  // Byte offsets of the registers
  localparam logic [7:0]  CRR_OFS_RESULT_0 = 8'h00;
  localparam logic [7:0]  CRR_OFS_RESULT_1 = 8'h04;
  localparam logic [7:0]  CRR_OFS_RESULT_2 = 8'h08;
  localparam logic [7:0]  CRR_OFS_RESULT_3 = 8'h0c;
  localparam logic [7:0]  CRR_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0]  CRR_OFS_IRQ_EN   = 8'h14;
  localparam logic [7:0]  CRR_OFS_IRQ_CLR  = 8'h18;

  // Field positions inside a result register
  localparam int unsigned CRR_VALUE_LSB    = 4;
  localparam int unsigned CRR_VALUE_MSB    = 15;
  localparam int unsigned CRR_OVR_BIT      = 1;
  localparam int unsigned CRR_STORED_BIT   = 0;

  // Field positions of the event bits
  localparam int unsigned CRR_EVT_STORE_LSB = 0;
  localparam int unsigned CRR_EVT_OVR_LSB   = 4;

  // Values after reset
  localparam logic [11:0] CRR_VALUE_RST    = 12'h000;
  localparam logic [31:0] CRR_WORD_RST     = 32'h0000_0000;
  localparam logic [7:0]  CRR_EVT_RST      = 8'h00;

  // Store strobe from the conversion sequencer
  typedef struct packed {
    logic        valid;
    logic [1:0]  index;
    logic [11:0] data;
  } crr_store_t;

  // APB request and answer
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } crr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } crr_apb_rsp_t;

  typedef enum logic {CRR_BUS_IDLE, CRR_BUS_ACCESS} crr_bus_state_t;

  typedef struct packed {
    logic [11:0] value;
    logic        stored;
    logic        overrun;
  } crr_slot_state_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] enable;
    logic       irq;
  } crr_irq_state_t;

  typedef struct packed {
    crr_bus_state_t bus;
    crr_apb_rsp_t   rsp;
  } crr_top_state_t;

endpackage

// ### crr_slot.sv
// One conversion result register with its stored and overrun flags.
// Assumes store and read clear come from logic on the same clock.
`timescale 1ns/100ps
module crr_slot (
  input  wire logic        clk,      // System clock
  input  wire logic        rst_n,    // Asynchronous reset, active low
  input  wire logic        store,    // Load a new result this cycle
  input  wire logic [11:0] data,     // Result to load
  input  wire logic        rd_clr,   // Software reads the low byte
  output logic      [11:0] value,    // Held result
  output logic             stored,   // Unread result present
  output logic             overrun   // Result lost before being read
);
  import crr_pkg::*;

  crr_slot_state_t state_reg;
  crr_slot_state_t state_next;

  // Store wins over the read clear of the same cycle for value and stored; the clear still zeroes overrun
  always_comb begin
    state_next = state_reg;
    if (store) begin
      state_next.value   = data;
      state_next.stored  = 1'b1;
      state_next.overrun = state_reg.overrun |
                           (state_reg.stored & ~rd_clr);
      if (rd_clr) begin
        state_next.overrun = 1'b0;
      end
    end else if (rd_clr) begin
      state_next.stored  = 1'b0;
      state_next.overrun = 1'b0;
    end
  end

  // State register, cleared by reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{value: CRR_VALUE_RST, stored: 1'b0,
                     overrun: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign value   = state_reg.value;
  assign stored  = state_reg.stored;
  assign overrun = state_reg.overrun;

endmodule

// ### crr_irq.sv
// Sticky event status, enable mask and level interrupt output.
// Assumes the bus slave gives one-cycle write strobes on the same clock.
`timescale 1ns/100ps
module crr_irq (
  input  wire logic       clk,       // System clock
  input  wire logic       rst_n,     // Asynchronous reset, active low
  input  wire logic [7:0] set,       // Event pulses, one per bit
  input  wire logic       en_we,     // Write strobe of enable register
  input  wire logic [7:0] en_data,   // New enable mask
  input  wire logic       clr_we,    // Write strobe of clear register
  input  wire logic [7:0] clr_data,  // Ones clear status bits
  output logic      [7:0] status,    // Sticky status bits
  output logic      [7:0] enable,    // Enable mask
  output logic            irq        // Level interrupt, active high
);
  import crr_pkg::*;

  crr_irq_state_t state_reg;
  crr_irq_state_t state_next;

  // A set in the cycle of its clear is kept
  always_comb begin
    state_next = state_reg;
    if (clr_we) begin
      state_next.status = state_reg.status & ~clr_data;
    end
    state_next.status = state_next.status | set;
    if (en_we) begin
      state_next.enable = en_data;
    end
    state_next.irq = |(state_next.status & state_next.enable);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{status: CRR_EVT_RST, enable: CRR_EVT_RST, irq: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign status = state_reg.status;
  assign enable = state_reg.enable;
  assign irq    = state_reg.irq;

endmodule

// ### crr_top.sv
// Top of the conversion result register block: APB slave, four result
// registers and the event interrupt.
// Assumes an APB master on clk and a store strobe from the sequencer
// that runs on the same clock, so no input is synchronised.
`timescale 1ns/100ps
module crr_top (
  input  wire logic                  clk,      // System clock, 125 MHz
  input  wire logic                  rst_n,    // Async reset, active low
  input  wire crr_pkg::crr_apb_req_t apb_req,  // APB request from master
  input  wire crr_pkg::crr_store_t   store,    // Result store strobe
  output crr_pkg::crr_apb_rsp_t      apb_rsp,  // APB answer, registered
  output logic                       irq       // Event interrupt, high
);
  import crr_pkg::*;

  // Register state of the bus slave
  crr_top_state_t state_reg;
  crr_top_state_t state_next;

  // Per slot signals
  logic [3:0]  store_hit;
  logic [3:0]  rd_clr;
  logic [11:0] slot_value [CRR_NUM_SLOTS];
  logic [3:0]  slot_stored;
  logic [3:0]  slot_overrun;

  // Bus decode of the current cycle
  logic        setup_phase;
  logic        access_done;
  logic [3:0]  addr_slot;
  logic        addr_mapped;
  logic [31:0] read_word;

  // Interrupt block connections
  logic [7:0]  evt_set;
  logic [7:0]  evt_store;
  logic [7:0]  evt_ovr;
  logic        en_we;
  logic        clr_we;
  logic [7:0]  irq_status;
  logic [7:0]  irq_enable;
  logic        irq_line;

  // Decode of a byte address onto the result registers, one hot
  function automatic logic [3:0] slot_select(input logic [7:0] addr);
    logic [3:0] hit;
    hit = 4'h0;
    case (addr)
      CRR_OFS_RESULT_0: hit = 4'h1;
      CRR_OFS_RESULT_1: hit = 4'h2;
      CRR_OFS_RESULT_2: hit = 4'h4;
      CRR_OFS_RESULT_3: hit = 4'h8;
      default:          hit = 4'h0;
    endcase
    return hit;
  endfunction

  // Decode of a store index onto the result registers, one hot
  function automatic logic [3:0] index_select(input logic [1:0] idx);
    logic [3:0] hit;
    hit = 4'h0;
    hit[idx] = 1'b1;
    return hit;
  endfunction

  // Packing of one result register into its bus word
  function automatic logic [31:0] pack_result(
    input logic [11:0] value,
    input logic        stored,
    input logic        overrun
  );
    logic [31:0] word;
    word = CRR_WORD_RST;
    word[CRR_VALUE_MSB:CRR_VALUE_LSB] = value;
    word[CRR_OVR_BIT]    = overrun;
    word[CRR_STORED_BIT] = stored;
    return word;
  endfunction

  // Widening of an 8-bit register into its bus word
  function automatic logic [31:0] pack_byte(input logic [7:0] b);
    logic [31:0] word;
    word = CRR_WORD_RST;
    word[7:0] = b;
    return word;
  endfunction

  // Phase detection of the APB transfer
  assign setup_phase = apb_req.psel & ~apb_req.penable &
                       (state_reg.bus == CRR_BUS_IDLE);
  assign access_done = apb_req.psel & apb_req.penable &
                       state_reg.rsp.pready &
                       (state_reg.bus == CRR_BUS_ACCESS);

  // Address decode
  assign addr_slot   = slot_select(apb_req.paddr);
  assign addr_mapped = (|addr_slot) |
                       (apb_req.paddr == CRR_OFS_IRQ_STAT) |
                       (apb_req.paddr == CRR_OFS_IRQ_EN) |
                       (apb_req.paddr == CRR_OFS_IRQ_CLR);

  // Store strobe routed to its own register only
  assign store_hit = store.valid ? index_select(store.index)
                                 : 4'h0;

  // A read is taken at its setup edge, which clears that register's
  // flags; an APB read always covers the low byte
  assign rd_clr = (setup_phase & ~apb_req.pwrite) ? addr_slot
                                                  : 4'h0;

  // Four result registers
  genvar gi;
  generate
    for (gi = 0; gi < CRR_NUM_SLOTS; gi++) begin : g_slot
      crr_slot u_slot (
        .clk     (clk),
        .rst_n   (rst_n),
        .store   (store_hit[gi]),
        .data    (store.data),
        .rd_clr  (rd_clr[gi]),
        .value   (slot_value[gi]),
        .stored  (slot_stored[gi]),
        .overrun (slot_overrun[gi])
      );
    end
  endgenerate

  // Events: every store, and every store over an unread result
  always_comb begin
    evt_store = CRR_EVT_RST;
    evt_ovr   = CRR_EVT_RST;
    for (int i = 0; i < CRR_NUM_SLOTS; i++) begin
      evt_store[CRR_EVT_STORE_LSB + i] = store_hit[i];
      evt_ovr[CRR_EVT_OVR_LSB + i]     = store_hit[i] &
                                         slot_stored[i] &
                                         ~rd_clr[i];
    end
    evt_set = evt_store | evt_ovr;
  end

  // Write strobes of the interrupt registers at the access edge,
  // byte lane 0 only since both registers are eight bits wide
  assign en_we  = access_done & apb_req.pwrite & apb_req.pstrb[0] &
                  (apb_req.paddr == CRR_OFS_IRQ_EN);
  assign clr_we = access_done & apb_req.pwrite & apb_req.pstrb[0] &
                  (apb_req.paddr == CRR_OFS_IRQ_CLR);

  // Sticky status, enable and interrupt line
  crr_irq u_irq (
    .clk      (clk),
    .rst_n    (rst_n),
    .set      (evt_set),
    .en_we    (en_we),
    .en_data  (apb_req.pwdata[7:0]),
    .clr_we   (clr_we),
    .clr_data (apb_req.pwdata[7:0]),
    .status   (irq_status),
    .enable   (irq_enable),
    .irq      (irq_line)
  );

  // Read data mux; the clear register and unmapped space read zero
  always_comb begin
    read_word = CRR_WORD_RST;
    case (apb_req.paddr)
      CRR_OFS_RESULT_0: read_word = pack_result(slot_value[0],
                                                slot_stored[0],
                                                slot_overrun[0]);
      CRR_OFS_RESULT_1: read_word = pack_result(slot_value[1],
                                                slot_stored[1],
                                                slot_overrun[1]);
      CRR_OFS_RESULT_2: read_word = pack_result(slot_value[2],
                                                slot_stored[2],
                                                slot_overrun[2]);
      CRR_OFS_RESULT_3: read_word = pack_result(slot_value[3],
                                                slot_stored[3],
                                                slot_overrun[3]);
      CRR_OFS_IRQ_STAT: read_word = pack_byte(irq_status);
      CRR_OFS_IRQ_EN:   read_word = pack_byte(irq_enable);
      default:          read_word = CRR_WORD_RST;
    endcase
  end

  // Bus slave: answer with pready in the first access cycle; the read
  // word and the error flag are captured at the setup edge. Writes to
  // result and status registers are ignored without error.
  always_comb begin
    state_next = state_reg;
    case (state_reg.bus)
      CRR_BUS_IDLE: begin
        if (setup_phase) begin
          state_next.bus         = CRR_BUS_ACCESS;
          state_next.rsp.pready  = 1'b1;
          state_next.rsp.pslverr = ~addr_mapped;
          if (apb_req.pwrite) begin
            state_next.rsp.prdata = CRR_WORD_RST;
          end else begin
            state_next.rsp.prdata = read_word;
          end
        end
      end
      CRR_BUS_ACCESS: begin
        if (access_done || !apb_req.psel) begin
          state_next.bus         = CRR_BUS_IDLE;
          state_next.rsp.pready  = 1'b0;
          state_next.rsp.pslverr = 1'b0;
          state_next.rsp.prdata  = CRR_WORD_RST;
        end
      end
      default: begin
        state_next.bus = CRR_BUS_IDLE;
        state_next.rsp = '{prdata: CRR_WORD_RST, pready: 1'b0,
                           pslverr: 1'b0};
      end
    endcase
  end

  // Bus slave register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{bus: CRR_BUS_IDLE,
                     rsp: '{prdata: CRR_WORD_RST, pready: 1'b0,
                            pslverr: 1'b0}};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from registers
  assign apb_rsp = state_reg.rsp;
  assign irq     = irq_line;

endmodule

// ### crr_monitor.sv
// Checker of the result register block, watching the top ports only.
// Assumes one clock and the zero-wait APB timing of the slave.
`timescale 1ns/100ps
module crr_monitor (
  input wire logic                  clk,      // System clock
  input wire logic                  rst_n,    // Async reset, active low
  input wire crr_pkg::crr_apb_req_t apb_req,  // APB request
  input wire crr_pkg::crr_store_t   store,    // Store strobe
  input wire crr_pkg::crr_apb_rsp_t apb_rsp,  // APB answer
  input wire logic                  irq       // Interrupt
);
  import crr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Decoded bus phases
  logic setup, rd_res, acc_wr, sv;
  assign setup  = apb_req.psel & ~apb_req.penable;
  assign rd_res = setup & ~apb_req.pwrite & (apb_req.paddr < 8'h10);
  assign acc_wr = apb_req.psel & apb_req.penable & apb_req.pwrite
                & apb_rsp.pready & apb_req.pstrb[0];
  assign sv     = store.valid;

  // Store, one quiet cycle, then a read of that same register
  sequence s_store_read;
    sv ##1 (!sv && !setup) ##1
    (rd_res && !sv && apb_req.paddr[3:2] == $past(store.index, 2));
  endsequence
  // Two reads of one register with no store between them
  sequence s_read_twice;
    (rd_res && !sv) ##1 (!sv)[*2] ##1
    (rd_res && !sv && apb_req.paddr == $past(apb_req.paddr, 3));
  endsequence

  a_ready_after_setup: assert property (setup |=> apb_rsp.pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  a_spare_bits_zero: assert property (
    apb_rsp.pready && !apb_req.pwrite && apb_req.paddr < 8'h10
    |-> apb_rsp.prdata[31:16] == 16'h0000 && apb_rsp.prdata[3:2] == 2'b00)
    else $error("spare result bits not zero");
  a_store_then_read: assert property (
    s_store_read |=> apb_rsp.prdata[15:4] == $past(store.data, 3)
    && apb_rsp.prdata[0])
    else $error("stored result not seen");
  a_read_clears_flags: assert property (
    s_read_twice |=> apb_rsp.prdata[1:0] == 2'b00)
    else $error("flags survive a read");
  a_irq_clear_all: assert property (
    acc_wr && apb_req.paddr == 8'h18 && apb_req.pwdata[7:0] == 8'hff
    && !sv |=> !irq)
    else $error("irq stays after clear");
  a_irq_mask_off: assert property (
    (acc_wr && apb_req.paddr == 8'h14 && apb_req.pwdata[7:0] == 8'h00
    && !sv) ##1 !sv |=> !irq)
    else $error("irq with mask off");
  a_unmapped_error: assert property (setup && apb_req.paddr > 8'h18
    |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_idle_quiet: assert property (!apb_rsp.pready
    |-> apb_rsp.prdata == 32'h0000_0000 && !apb_rsp.pslverr)
    else $error("answer outside access");
endmodule

bind crr_top crr_monitor u_mon (
  .clk     (clk),
  .rst_n   (rst_n),
  .apb_req (apb_req),
  .store   (store),
  .apb_rsp (apb_rsp),
  .irq     (irq)
);

// ### crr_top_tb.sv
// Self-checking bench of the result register block over APB.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/100ps
module crr_top_tb;
  import crr_pkg::*;
  logic         clk;
  logic         rst_n;
  logic         irq;
  logic         err;
  logic [31:0]  rd;
  crr_apb_req_t req;
  crr_store_t   st;
  crr_apb_rsp_t rsp;
  int           fails;
  int           samples_checked;
  int           cycles;
  logic [11:0]  dv [4] = '{12'hfff, 12'h001, 12'h5a3, 12'h800};

  crr_top dut (.clk(clk), .rst_n(rst_n), .apb_req(req), .store(st),
               .apb_rsp(rsp), .irq(irq));

  // Clock of 8 ns period
  always #4 clk = ~clk;

  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails = fails + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; answer taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    req.pstrb <= 4'hf;
    @(posedge clk);
    req.penable <= 1'b1;
    // Read before this edge's register updates land: the sampled value
    @(posedge clk);
    while (rsp.pready !== 1'b1) @(posedge clk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // One-cycle store pulse from the sequencer side
  task automatic put(input logic [1:0] i, input logic [11:0] d);
    @(posedge clk);
    st <= '{1'b1, i, d};
    @(posedge clk);
    st.valid <= 1'b0;
  endtask

  task automatic irqchk(input logic e);
    repeat (2) @(negedge clk);
    check({31'h0000_0000, irq}, {31'h0000_0000, e});
  endtask

  function automatic logic [31:0] w(input logic [11:0] d,
                                    input logic [1:0] f);
    return {16'h0000, d, 2'b00, f};
  endfunction

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    st = '0;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(8'(i * 4), 32'h0000_0000);
    for (int i = 0; i < 4; i++) put(2'(i), dv[i]);
    for (int i = 0; i < 4; i++) rdchk(8'(i * 4), w(dv[i], 2'b01));
    for (int i = 0; i < 4; i++) rdchk(8'(i * 4), w(dv[i], 2'b00));
    rdchk(8'h10, 32'h0000_000f);
    apb(1'b1, 8'h18, 32'h0000_00ff);
    rdchk(8'h10, 32'h0000_0000);
    irqchk(1'b0);
    // Second store before a read raises overrun
    put(2'd2, 12'h123);
    put(2'd2, 12'habc);
    rdchk(8'h08, w(12'habc, 2'b11));
    rdchk(8'h08, w(12'habc, 2'b00));
    rdchk(8'h10, 32'h0000_0044);
    // Interrupt enabled, masked, enabled and cleared
    apb(1'b1, 8'h14, 32'h0000_0040);
    irqchk(1'b1);
    rdchk(8'h14, 32'h0000_0040);
    apb(1'b1, 8'h14, 32'h0000_0000);
    irqchk(1'b0);
    apb(1'b1, 8'h14, 32'h0000_00ff);
    irqchk(1'b1);
    apb(1'b1, 8'h18, 32'h0000_00ff);
    irqchk(1'b0);
    rdchk(8'h10, 32'h0000_0000);
    // Writes to a result register are ignored
    apb(1'b1, 8'h04, 32'hffff_ffff);
    rdchk(8'h04, w(dv[1], 2'b00));
    // Reset in mid-run clears result, flags, enable and interrupt
    put(2'd1, 12'h7e7);
    apb(1'b1, 8'h14, 32'h0000_00ff);
    irqchk(1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    irqchk(1'b0);
    rdchk(8'h04, 32'h0000_0000);
    rdchk(8'h14, 32'h0000_0000);
    rdchk(8'h10, 32'h0000_0000);
    // Unmapped address is refused
    rdchk(8'h40, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    end_sim();
  end
endmodule
